// file: aeiu_analog_model.sv
// model of the supply monitor and comparator outputs
module aeiu_analog_model (
    // clock
    input  wire logic pclk,
    // monitor levels
    output logic      supply_ok,
    output logic      comparator_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // power good, comparator low at start
    initial begin
        supply_ok = 1'b1;
        comparator_out = 1'b0;
    end
    // move power-ok after an edge, then let capture settle
    task automatic set_supply(input logic v);
        @(posedge pclk);
        supply_ok <= v;
        repeat (3) @(posedge pclk);
    endtask
    // move the comparator output the same way
    task automatic set_comp(input logic v);
        @(posedge pclk);
        comparator_out <= v;
        repeat (3) @(posedge pclk);
    endtask
endmodule

// file: aeiu_event_detect.sv
// edge detection on the supply monitor, edge and level detection on the comparator output
module aeiu_event_detect (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // analog monitor levels
    input  wire logic supply_ok,
    input  wire logic comparator_out,
    // settings in, events out
    aeiu_event_if.det ev
);

    // ------------------------------------------------------------------
    // history of the monitored levels
    // ------------------------------------------------------------------
    logic primed;
    logic prev_ok;
    logic prev_comp;
    logic next_primed;
    logic next_prev_ok;
    logic next_prev_comp;
    logic comp_rise;
    logic comp_fall;
    logic comp_hit;

    // next history; first cycle only loads, so no false edge at reset
    always_comb begin
        next_primed    = 1'b1;
        next_prev_ok   = supply_ok;
        next_prev_comp = comparator_out;
    end

    // history registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primed    <= 1'b0;
            prev_ok   <= 1'b0;
            prev_comp <= 1'b0;
        end else begin
            primed    <= next_primed;
            prev_ok   <= next_prev_ok;
            prev_comp <= next_prev_comp;
        end
    end

    // ------------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------------
    always_comb begin
        comp_rise = primed & comparator_out & ~prev_comp;
        comp_fall = primed & ~comparator_out & prev_comp;
        comp_hit  = 1'b0;
        if (ev.level_sense == aeiu_pkg::SENSE_LEVEL) begin
            // 0x low level, 1x high level
            comp_hit = ev.polarity[1] ? comparator_out
                                      : ~comparator_out;
        end else begin
            unique case (ev.polarity)
                aeiu_pkg::POL_RISE: comp_hit = comp_rise;
                aeiu_pkg::POL_FALL: comp_hit = comp_fall;
                default:            comp_hit = comp_rise | comp_fall;
            endcase
        end
    end

    // events only while the bus clock of the block runs
    assign ev.recovered  = ev.enable & primed & supply_ok & ~prev_ok;
    assign ev.brownout   = ev.enable & primed & ~supply_ok & prev_ok;
    assign ev.comp_event = ev.enable & comp_hit;

endmodule

// file: aeiu_event_if.sv
// carrier between the register block and the event detector
interface aeiu_event_if;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic       enable;        // bus clock enable, capture allowed
    logic       level_sense;   // comparator level (1) or edge (0)
    logic [1:0] polarity;      // comparator polarity select
    logic       recovered;     // supply rose above threshold
    logic       brownout;      // supply fell below threshold
    logic       comp_event;    // comparator condition met

    // ------------------------------------------------------------------
    // views
    // ------------------------------------------------------------------
    modport regs (
        output enable,
        output level_sense,
        output polarity,
        input  recovered,
        input  brownout,
        input  comp_event
    );
    modport det (
        input  enable,
        input  level_sense,
        input  polarity,
        output recovered,
        output brownout,
        output comp_event
    );
endinterface

// file: aeiu_pkg.sv
// constants, types and decode helpers of the analog event interrupt unit
package aeiu_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL     = 12'h0a00;
    localparam logic [11:0] OFF_RAW      = 12'h0a08;
    localparam logic [11:0] OFF_ENS      = 12'h0a0c;
    localparam logic [11:0] OFF_ENC      = 12'h0a10;
    localparam logic [11:0] OFF_MASKED   = 12'h0a14;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          BIT_BROWNOUT  = 0;
    localparam int          BIT_COMP      = 3;
    localparam int          BIT_RECOVERED = 4;
    localparam int          BIT_LEVEL     = 0;
    localparam int          BIT_POL_LO    = 1;
    localparam int          BIT_POL_HI    = 2;
    localparam int          SRC_W         = 5;
    localparam logic [4:0]  SRC_MASK      = 5'h19;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [4:0]  RST_PENDING  = 5'h00;
    localparam logic [4:0]  RST_ENABLE   = 5'h00;
    localparam logic        RST_LEVEL    = 1'b0;
    localparam logic [1:0]  RST_POL      = 2'h0;
    localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // comparator sense codes
    // ------------------------------------------------------------------
    localparam logic        SENSE_EDGE   = 1'b0;
    localparam logic        SENSE_LEVEL  = 1'b1;
    localparam logic [1:0]  POL_RISE     = 2'h0;
    localparam logic [1:0]  POL_FALL     = 2'h1;

    // ------------------------------------------------------------------
    // register select
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        REG_NONE   = 3'b000,
        REG_CTRL   = 3'b001,
        REG_RAW    = 3'b010,
        REG_ENS    = 3'b011,
        REG_ENC    = 3'b100,
        REG_MASKED = 3'b101
    } aeiu_reg_type;

    // map a byte address onto a register
    function automatic aeiu_reg_type aeiu_decode(input logic [11:0] addr);
        aeiu_reg_type sel;
        sel = REG_NONE;
        case (addr)
            OFF_CTRL:   sel = REG_CTRL;
            OFF_RAW:    sel = REG_RAW;
            OFF_ENS:    sel = REG_ENS;
            OFF_ENC:    sel = REG_ENC;
            OFF_MASKED: sel = REG_MASKED;
            default:    sel = REG_NONE;
        endcase
        return sel;
    endfunction

    // widen a source vector to a bus word, reserved bits zero
    function automatic logic [31:0] aeiu_word(input logic [4:0] src);
        return {27'h000_0000, src & SRC_MASK};
    endfunction

endpackage

// file: aeiu_top.sv
// analog event interrupt unit: APB register block and interrupt request
module aeiu_top #(
    parameter int ADDR_W = aeiu_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // bus clock gate of the block
    input  wire logic              analog_irq_bus_clock_enable,
    // analog monitor outputs
    input  wire logic              supply_ok,
    input  wire logic              comparator_out,
    // interrupt request
    output logic                   irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    aeiu_event_if ev ();

    logic [4:0]             pending;
    logic [4:0]             enable;
    logic                   level_sense;
    logic [1:0]             polarity;
    logic [4:0]             next_pending;
    logic [4:0]             next_enable;
    logic                   next_level_sense;
    logic [1:0]             next_polarity;
    logic [31:0]            next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;
    logic                   next_irq;

    logic                   acc_setup;
    logic                   acc_done;
    logic                   wr_ok;
    logic                   setup_bad;
    aeiu_pkg::aeiu_reg_type sel;
    logic [4:0]             set_ev;
    logic [4:0]             wr_bits;
    logic [4:0]             raw_clr;
    logic [4:0]             en_set;
    logic [4:0]             en_clr;
    logic [31:0]            rd_word;

    // ------------------------------------------------------------------
    // event detector
    // ------------------------------------------------------------------

    // settings towards the detector
    assign ev.enable      = analog_irq_bus_clock_enable;
    assign ev.level_sense = level_sense;
    assign ev.polarity    = polarity;

    aeiu_event_detect u_detect (
        .pclk           (pclk),
        .presetn        (presetn),
        .supply_ok      (supply_ok),
        .comparator_out (comparator_out),
        .ev             (ev)
    );

    // gather detector pulses at their status positions
    always_comb begin
        set_ev = 5'h00;
        set_ev[aeiu_pkg::BIT_RECOVERED] = ev.recovered;
        set_ev[aeiu_pkg::BIT_COMP]      = ev.comp_event;
        set_ev[aeiu_pkg::BIT_BROWNOUT]  = ev.brownout;
    end

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------

    // phases of the apb transfer and the register addressed
    always_comb begin
        acc_setup = psel & ~penable;
        acc_done  = psel & penable & pready;
        sel       = aeiu_pkg::aeiu_decode(paddr[11:0]);
        // refused when the bus clock is off or nothing is mapped
        setup_bad = ~analog_irq_bus_clock_enable
                    | (sel == aeiu_pkg::REG_NONE);
        wr_ok     = acc_done & pwrite & ~pslverr;
        wr_bits   = pwdata[4:0] & aeiu_pkg::SRC_MASK;
    end

    // read multiplexer, reserved bits read zero
    always_comb begin
        rd_word = aeiu_pkg::RST_RDATA;
        unique case (sel)
            aeiu_pkg::REG_CTRL: begin
                rd_word[aeiu_pkg::BIT_LEVEL]  = level_sense;
                rd_word[aeiu_pkg::BIT_POL_LO] = polarity[0];
                rd_word[aeiu_pkg::BIT_POL_HI] = polarity[1];
            end
            aeiu_pkg::REG_RAW: begin
                rd_word = aeiu_pkg::aeiu_word(pending);
            end
            aeiu_pkg::REG_ENS: begin
                rd_word = aeiu_pkg::aeiu_word(enable);
            end
            aeiu_pkg::REG_ENC: begin
                rd_word = aeiu_pkg::RST_RDATA;   // write only
            end
            aeiu_pkg::REG_MASKED: begin
                rd_word = aeiu_pkg::aeiu_word(pending & enable);
            end
            aeiu_pkg::REG_NONE: begin
                rd_word = aeiu_pkg::RST_RDATA;
            end
            default: begin
                rd_word = aeiu_pkg::RST_RDATA;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------

    // answer in the first access cycle, data latched at setup
    always_comb begin
        next_pready  = acc_setup;
        next_pslverr = acc_setup & setup_bad;
        next_prdata  = prdata;
        if (acc_setup) begin
            next_prdata = aeiu_pkg::RST_RDATA;
            if (!pwrite && !setup_bad) begin
                next_prdata = rd_word;
            end
        end
    end

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= aeiu_pkg::RST_RDATA;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // pending, enable and control state
    // ------------------------------------------------------------------

    // write strobes per register
    always_comb begin
        raw_clr = 5'h00;
        en_set  = 5'h00;
        en_clr  = 5'h00;
        if (wr_ok && sel == aeiu_pkg::REG_RAW) begin
            raw_clr = wr_bits;
        end
        if (wr_ok && sel == aeiu_pkg::REG_ENS) begin
            en_set = wr_bits;
        end
        if (wr_ok && sel == aeiu_pkg::REG_ENC) begin
            en_clr = wr_bits;
        end
    end

    // next state; an event in the clear cycle keeps its flag set
    always_comb begin
        next_pending     = (pending & ~raw_clr) | set_ev;
        next_enable      = (enable | en_set) & ~en_clr;
        next_level_sense = level_sense;
        next_polarity    = polarity;
        if (wr_ok && sel == aeiu_pkg::REG_CTRL) begin
            next_level_sense = pwdata[aeiu_pkg::BIT_LEVEL];
            next_polarity    = pwdata[aeiu_pkg::BIT_POL_HI:
                                      aeiu_pkg::BIT_POL_LO];
        end
        // request follows the masked view of the new state
        next_irq = |(next_pending & next_enable
                     & aeiu_pkg::SRC_MASK);
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending     <= aeiu_pkg::RST_PENDING;
            enable      <= aeiu_pkg::RST_ENABLE;
            level_sense <= aeiu_pkg::RST_LEVEL;
            polarity    <= aeiu_pkg::RST_POL;
            irq         <= 1'b0;
        end else begin
            pending     <= next_pending;
            enable      <= next_enable;
            level_sense <= next_level_sense;
            polarity    <= next_polarity;
            irq         <= next_irq;
        end
    end

endmodule

// file: aeiu_top_properties.sv
// port checker of the analog event interrupt unit
module aeiu_top_properties #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb slave
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // gate, monitors and request
    input wire logic              analog_irq_bus_clock_enable,
    input wire logic              supply_ok,
    input wire logic              comparator_out,
    input wire logic              irq
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic       setup;
    logic       commit;
    logic       mapped;
    logic       gate;
    logic [4:0] en_mask;
    logic [4:0] next_en_mask;
    assign gate   = analog_irq_bus_clock_enable;
    assign setup  = psel && !penable;
    assign commit = psel && penable && pready && pwrite && gate;
    assign mapped = paddr == 12'h0a00 || paddr == 12'h0a08
                 || paddr == 12'h0a0c || paddr == 12'h0a10
                 || paddr == 12'h0a14;
    // enable mask as software last set it
    always_comb begin
        next_en_mask = en_mask;
        if (commit && paddr == 12'h0a0c)
            next_en_mask = en_mask | (pwdata[4:0] & 5'h19);
        if (commit && paddr == 12'h0a10)
            next_en_mask = en_mask & ~pwdata[4:0];
    end
    // mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en_mask <= 5'h00;
        else
            en_mask <= next_en_mask;
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    ready_one_cycle_a:
        assert property (setup |=> pready ##1 !pready)
            else $error("pready is not a one-cycle answer");
    gated_refusal_a:
        assert property ((setup && !gate) |=> pslverr)
            else $error("gated access not refused");
    unmapped_refusal_a:
        assert property ((setup && !mapped) |=> pslverr && prdata == 0)
            else $error("unmapped access not refused");
    error_with_ready_a:
        assert property (pslverr |-> pready)
            else $error("error without ready");
    mask_readback_a:
        assert property ((setup && !pwrite && gate && paddr == 12'h0a0c)
            |=> prdata == {27'h000_0000, $past(en_mask)})
            else $error("enable mask read wrong");
    clear_drops_irq_a:
        assert property ((setup && pwrite && gate && paddr == 12'h0a10
            && (pwdata[4:0] & 5'h19) == 5'h19) |=> ##1 !irq)
            else $error("request stays after enable clear");
    brownout_raises_a:
        assert property (($fell(supply_ok) && gate && en_mask[0])
            |-> ##[1:2] irq)
            else $error("brown-out raised no request");
    recovery_raises_a:
        assert property (($rose(supply_ok) && gate && en_mask[4])
            |-> ##[1:2] irq)
            else $error("recovery raised no request");
    irq_fall_cause_a:
        assert property ($fell(irq) |-> $past(psel && penable && pwrite))
            else $error("request fell without a write");
    irq_needs_enable_a:
        assert property (irq |-> en_mask != 5'h00)
            else $error("request with no source enabled");
    cover property (setup && pwrite && paddr == 12'h0a08);
    cover property ($rose(irq));
    cover property (setup && !gate);
endmodule

bind aeiu_top aeiu_top_properties #(.ADDR_W(ADDR_W)) aeiu_top_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .analog_irq_bus_clock_enable(analog_irq_bus_clock_enable),
    .supply_ok(supply_ok), .comparator_out(comparator_out), .irq(irq)
);

// file: aeiu_top_test.sv
// self-checking bench of the analog event interrupt unit
module aeiu_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        bus_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        supply_ok;
    logic        comparator_out;
    logic [31:0] rd;
    logic        err;
    logic [2:0]  code;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    aeiu_top aeiu_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .analog_irq_bus_clock_enable(bus_en), .supply_ok(supply_ok),
        .comparator_out(comparator_out), .irq(irq)
    );
    aeiu_analog_model aeiu_analog_model_inst (
        .pclk(pclk), .supply_ok(supply_ok), .comparator_out(comparator_out)
    );
    // free-running bus clock, 5 ns period
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s %h not %h", $time, what,
                     seen, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the wait ends when pready is sampled high; only the hang guard stops it if pready never comes
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input string what);
        xfer(a, 1'b0, 32'h0000_0000);
        check(rd, exp, what);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d, comparisons %0d", bad_count,
                 samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        // idle bus, gate off, reset asserted
        presetn <= 1'b0;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
        paddr   <= 12'h0000;
        pwdata  <= 32'h0000_0000;
        bus_en  <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(12'h0a08, 1'b0, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001, "gated err");
        aeiu_analog_model_inst.set_supply(1'b0);
        aeiu_analog_model_inst.set_supply(1'b1);
        bus_en <= 1'b1;
        @(posedge pclk);
        rd_chk(12'h0a08, 32'h0000_0000, "gated raw");
        rd_chk(12'h0a0c, 32'h0000_0000, "mask reset");
        rd_chk(12'h0a14, 32'h0000_0000, "masked reset");
        xfer(12'h0a0c, 1'b1, 32'h0000_0019);
        rd_chk(12'h0a0c, 32'h0000_0019, "set all");
        xfer(12'h0a10, 1'b1, 32'h0000_0008);
        rd_chk(12'h0a0c, 32'h0000_0011, "clear one");
        xfer(12'h0a0c, 1'b1, 32'h0000_0000);
        rd_chk(12'h0a0c, 32'h0000_0011, "zero set");
        aeiu_analog_model_inst.set_supply(1'b0);
        rd_chk(12'h0a08, 32'h0000_0001, "brownout");
        rd_chk(12'h0a14, 32'h0000_0001, "masked");
        check({31'h0000_0000, irq}, 32'h0000_0001, "irq high");
        aeiu_analog_model_inst.set_supply(1'b1);
        rd_chk(12'h0a08, 32'h0000_0011, "recovered");
        xfer(12'h0a08, 1'b1, 32'h0000_0001);
        rd_chk(12'h0a08, 32'h0000_0010, "w1c raw");
        xfer(12'h0a14, 1'b1, 32'h0000_0019);
        rd_chk(12'h0a14, 32'h0000_0010, "masked ro");
        xfer(12'h0a10, 1'b1, 32'h0000_0010);
        rd_chk(12'h0a14, 32'h0000_0000, "masked off");
        check({31'h0000_0000, irq}, 32'h0000_0000, "irq low");
        rd_chk(12'h0a08, 32'h0000_0010, "raw kept");
        xfer(12'h0a08, 1'b1, 32'h0000_0010);
        rd_chk(12'h0a08, 32'h0000_0000, "raw clear");
        rd_chk(12'h0a04, 32'h0000_0000, "unmapped");
        check({31'h0000_0000, err}, 32'h0000_0001, "unmapped");
        xfer(12'h0a0c, 1'b1, 32'h0000_0008);
        // every sense and polarity code on the comparator
        for (int c = 0; c < 8; c++) begin
            code = 3'(c);
            xfer(12'h0a00, 1'b1, {29'h0000_0000, code});
            xfer(12'h0a08, 1'b1, 32'h0000_0019);
            if (code[0] == aeiu_pkg::SENSE_EDGE) begin
                aeiu_analog_model_inst.set_comp(1'b1);
                rd_chk(12'h0a08, {28'h000_0000, code[2:1] != 2'b01, 3'h0},
                       "rise");
                xfer(12'h0a08, 1'b1, 32'h0000_0019);
                aeiu_analog_model_inst.set_comp(1'b0);
                rd_chk(12'h0a08, {28'h000_0000, code[2:1] != 2'b00, 3'h0},
                       "fall");
                xfer(12'h0a08, 1'b1, 32'h0000_0019);
            end else begin
                rd_chk(12'h0a08, {28'h000_0000, ~code[2], 3'h0},
                       "level");
                check({31'h0000_0000, irq}, {31'h0000_0000, ~code[2]},
                      "level irq");
            end
        end
        xfer(12'h0a00, 1'b1, 32'h0000_0001);
        xfer(12'h0a10, 1'b1, 32'h0000_0019);
        check({31'h0000_0000, irq}, 32'h0000_0000, "all off");
        rd_chk(12'h0a14, 32'h0000_0000, "masked none");
        rd_chk(12'h0a08, 32'h0000_0008, "comp raw");
        tally_and_finish;
    end
endmodule
